// *** rtl/sfp_pin_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sfp_consts.svh"
module sfp_pin_ctl (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic [3:0] lane_in,
    output logic [3:0] lane_out,
    output logic [3:0] lane_oe,
    input wire logic [7:0] status_reg2,
    input wire logic [7:0] status_reg3,
    input wire logic busy,
    output logic busy_seen,
    output logic prog_valid,
    input wire logic prog_ready,
    output logic [7:0] prog_data,
    output logic overrun,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    output logic rd_ready,
    output logic paused
);
    // link domain, rising edge
    typedef struct packed {
        logic [1:0] qe_sy;
        logic [1:0] role_sy;
        sfp_pkg::sfp_state_type state;
        logic [5:0] cnt;
        logic [7:0] cmd;
        logic [7:0] shreg;
        logic hi_phase;
        logic [7:0] wbyte;
        logic wtog;
        logic rtog;
        logic [7:0] cur;
    } sfp_link_type;
    // link domain, falling edge
    typedef struct packed {
        logic drive;
        logic [3:0] nib;
    } sfp_fall_type;
    // system domain
    typedef struct packed {
        logic [1:0] hold_sy;
        logic [1:0] wtog_sy;
        logic wtog_seen;
        logic [1:0] rtog_sy;
        logic rtog_seen;
        logic need;
        logic [7:0] rhold;
        logic rd_ready;
        logic [1:0] drv_sy;
        logic [3:0] nib_sy0;
        logic [3:0] nib_sy1;
        logic [3:0] lane_out;
        logic [3:0] lane_oe;
        logic push;
        logic [7:0] push_data;
        logic overrun;
        logic paused;
        logic busy_seen;
    } sfp_sys_type;

    sfp_link_type lk_ff, nxt_lk, fr_ff, kp_ff;
    sfp_fall_type fl_ff, nxt_fl;
    sfp_sys_type sy_ff, nxt_sy;
    logic hold_role;
    logic link_pause;
    logic pin_reset;
    logic link_rst;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [7:0] buf_out_data;

    // role chosen by quad enable, then by the role bit
    assign hold_role = !lk_ff.qe_sy[1] && !lk_ff.role_sy[1];
    assign link_pause = hold_role && !lane_in[3];
    assign pin_reset = !lk_ff.qe_sy[1] && lk_ff.role_sy[1]
        && !lane_in[3];
    assign link_rst = rst || cs_n || pin_reset;

    always_comb begin
        nxt_lk = lk_ff;
        nxt_lk.qe_sy = {lk_ff.qe_sy[0], status_reg2[`SFP_QE_POS]};
        nxt_lk.role_sy = {lk_ff.role_sy[0], status_reg3[`SFP_ROLE_POS]};
        if (!link_pause) begin
            case (lk_ff.state)
                sfp_pkg::ST_CMD: begin
                    nxt_lk.cmd = {lk_ff.cmd[6:0], lane_in[0]};
                    nxt_lk.cnt = lk_ff.cnt + 6'd1;
                    if (lk_ff.cnt == `SFP_CMD_BITS - 6'd1) begin
                        if ({lk_ff.cmd[6:0], lane_in[0]} == `SFP_CMD_QUAD_PROG
                            || {lk_ff.cmd[6:0], lane_in[0]}
                            == `SFP_CMD_QUAD_READ) begin
                            nxt_lk.state = sfp_pkg::ST_ADDR;
                        end else begin
                            nxt_lk.state = sfp_pkg::ST_SKIP;
                        end
                    end
                end
                sfp_pkg::ST_ADDR: begin
                    nxt_lk.cnt = lk_ff.cnt + 6'd1;
                    if (lk_ff.cnt == `SFP_ADDR_END - 6'd1) begin
                        nxt_lk.hi_phase = 1'b1;
                        if (lk_ff.cmd == `SFP_CMD_QUAD_PROG) begin
                            nxt_lk.state = sfp_pkg::ST_PROG;
                        end else begin
                            nxt_lk.state = sfp_pkg::ST_DUMMY;
                        end
                    end
                end
                sfp_pkg::ST_DUMMY: begin
                    nxt_lk.cnt = lk_ff.cnt + 6'd1;
                    if (lk_ff.cnt == `SFP_DUMMY_END - 6'd1) begin
                        nxt_lk.state = sfp_pkg::ST_READ;
                        nxt_lk.cur = sy_ff.rhold;
                        nxt_lk.rtog = !lk_ff.rtog;
                    end
                end
                sfp_pkg::ST_PROG: begin
                    nxt_lk.hi_phase = !lk_ff.hi_phase;
                    nxt_lk.shreg = {lk_ff.shreg[3:0], lane_in};
                    if (!lk_ff.hi_phase) begin
                        nxt_lk.wbyte = {lk_ff.shreg[3:0], lane_in};
                        nxt_lk.wtog = !lk_ff.wtog;
                    end
                end
                sfp_pkg::ST_READ: begin
                    nxt_lk.hi_phase = !lk_ff.hi_phase;
                    if (!lk_ff.hi_phase) begin
                        nxt_lk.cur = sy_ff.rhold;
                        nxt_lk.rtog = !lk_ff.rtog;
                    end
                end
                sfp_pkg::ST_SKIP: begin
                    nxt_lk.state = sfp_pkg::ST_SKIP;
                end
                default: begin
                    nxt_lk.state = sfp_pkg::ST_CMD;
                end
            endcase
        end
    end

    // command progress resets with the frame, toggles persist
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            fr_ff <= '0;
            fr_ff.hi_phase <= 1'b1;
        end else begin
            fr_ff <= nxt_lk;
        end
    end
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            kp_ff <= '0;
        end else begin
            kp_ff <= nxt_lk;
        end
    end
    // frame fields from the frame copy, the rest from the kept copy
    always_comb begin
        lk_ff = kp_ff;
        lk_ff.state = fr_ff.state;
        lk_ff.cnt = fr_ff.cnt;
        lk_ff.cmd = fr_ff.cmd;
        lk_ff.shreg = fr_ff.shreg;
        lk_ff.hi_phase = fr_ff.hi_phase;
    end

    // output launch on the falling edge, frozen while paused
    always_comb begin
        nxt_fl = fl_ff;
        if (!link_pause) begin
            nxt_fl.drive = (lk_ff.state == sfp_pkg::ST_READ);
            nxt_fl.nib = lk_ff.hi_phase ? lk_ff.cur[7:4]
                : lk_ff.cur[3:0];
        end
    end
    always_ff @(negedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            fl_ff <= '0;
        end else begin
            fl_ff <= nxt_fl;
        end
    end

    // system side: pin drive, data handoff, pause status
    always_comb begin
        nxt_sy = sy_ff;
        nxt_sy.hold_sy = {sy_ff.hold_sy[0], !cs_n && !lane_in[3]
            && !status_reg2[`SFP_QE_POS] && !status_reg3[`SFP_ROLE_POS]};
        nxt_sy.drv_sy = {sy_ff.drv_sy[0], fl_ff.drive && !cs_n};
        nxt_sy.nib_sy0 = fl_ff.nib;
        nxt_sy.nib_sy1 = sy_ff.nib_sy0;
        nxt_sy.paused = sy_ff.hold_sy[1];
        nxt_sy.lane_out = sy_ff.nib_sy1;
        nxt_sy.lane_oe = {4{sy_ff.drv_sy[1] && !sy_ff.hold_sy[1]}};
        nxt_sy.busy_seen = busy;
        nxt_sy.wtog_sy = {sy_ff.wtog_sy[0], lk_ff.wtog};
        nxt_sy.push = 1'b0;
        if (sy_ff.push && !buf_in_ready) begin
            nxt_sy.push = 1'b1;
        end
        if (sy_ff.wtog_sy[1] != sy_ff.wtog_seen) begin
            nxt_sy.wtog_seen = sy_ff.wtog_sy[1];
            nxt_sy.push_data = lk_ff.wbyte;
            nxt_sy.push = 1'b1;
            if (sy_ff.push && !buf_in_ready) begin
                nxt_sy.overrun = 1'b1;
            end
        end
        nxt_sy.rtog_sy = {sy_ff.rtog_sy[0], lk_ff.rtog};
        nxt_sy.rd_ready = 1'b0;
        if (sy_ff.rtog_sy[1] != sy_ff.rtog_seen) begin
            nxt_sy.rtog_seen = sy_ff.rtog_sy[1];
            nxt_sy.need = 1'b1;
        end
        if (sy_ff.need && rd_valid && !sy_ff.rd_ready) begin
            nxt_sy.rhold = rd_data;
            nxt_sy.rd_ready = 1'b1;
            nxt_sy.need = (sy_ff.rtog_sy[1] != sy_ff.rtog_seen);
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sy_ff <= '0;
            sy_ff.need <= 1'b1;
        end else begin
            sy_ff <= nxt_sy;
        end
    end

    sfp_buf2 #(.W(8)) u_prog_buf (
        .clk(sys_clk),
        .rst(rst),
        .in_valid(sy_ff.push),
        .in_ready(buf_in_ready),
        .in_data(sy_ff.push_data),
        .out_valid(buf_out_valid),
        .out_ready(prog_ready),
        .out_data(buf_out_data)
    );

    assign lane_out = sy_ff.lane_out;
    assign lane_oe = sy_ff.lane_oe;
    assign busy_seen = sy_ff.busy_seen;
    assign prog_valid = buf_out_valid;
    assign prog_data = buf_out_data;
    assign overrun = sy_ff.overrun;
    assign rd_ready = sy_ff.rd_ready;
    assign paused = sy_ff.paused;
endmodule // sfp_pin_ctl
`default_nettype wire

// *** rtl/sfp_consts.svh ***
// Operation
// - while pause is asserted the device ignores clock edges and lane input and floats its data outputs.
// - a pause only starts with chip select low and the serial clock low, and the host keeps to that.
// - a pause keeps the device selected and keeps the command state so the transfer resumes where it stopped.
// - a pause touches only the serial link and never a running self-timed program or erase cycle.
// - during the quad page program command lane 3 is an input and four bits are captured per rising edge.
// - during quad output reads lane 3 is driven and four bits are launched per falling edge.
// - with quad enable clear, bit 7 of the third status register picks the pause or the reset role.
// - with quad enable set, pause and reset are off and the pin is only a data lane.
// - quad enable sits in the second status register and switches the shared pins to data lanes.
// - command, address and input data are sampled on rising edges, output launched on falling edges.
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH
`define SFP_CMD_QUAD_PROG 8'h32
`define SFP_CMD_QUAD_READ 8'h6b
`define SFP_QE_POS 1
`define SFP_ROLE_POS 7
`define SFP_CMD_BITS 6'h08
`define SFP_ADDR_END 6'h20
`define SFP_DUMMY_END 6'h28
`define SFP_BYTE_RST 8'h00
`endif

// *** rtl/sfp_pkg.sv ***
package sfp_pkg;
    typedef enum logic [2:0] {
        ST_CMD = 3'b000,
        ST_ADDR = 3'b001,
        ST_DUMMY = 3'b010,
        ST_PROG = 3'b011,
        ST_READ = 3'b100,
        ST_SKIP = 3'b101
    } sfp_state_type;
endpackage

// *** rtl/sfp_buf2.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfp_buf2 #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic [1:0] cnt;
        logic vld;
    } sfp_buf_type;
    sfp_buf_type st_ff, nxt_st;
    logic push;
    logic pop;
    always_comb begin
        nxt_st = st_ff;
        push = in_valid && (st_ff.cnt != 2'd2);
        pop = out_valid && out_ready;
        if (pop) begin
            nxt_st.mem[0] = st_ff.mem[1];
        end
        if (push) begin
            if (pop) begin
                nxt_st.mem[st_ff.cnt - 2'd1] = in_data;
            end else begin
                nxt_st.mem[st_ff.cnt[0]] = in_data;
            end
        end
        nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
        nxt_st.vld = (nxt_st.cnt != 2'd0);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign in_ready = (st_ff.cnt != 2'd2);
    assign out_valid = st_ff.vld;
    assign out_data = st_ff.mem[0];
endmodule // sfp_buf2
`default_nettype wire

// *** sim/sfp_pin_ctl_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfp_pin_ctl_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic [3:0] lane_in,
    input wire logic [3:0] lane_oe,
    input wire logic [7:0] status_reg2,
    input wire logic [7:0] status_reg3,
    input wire logic busy,
    input wire logic busy_seen,
    input wire logic prog_valid,
    input wire logic prog_ready,
    input wire logic [7:0] prog_data,
    input wire logic paused
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence s_off;
        cs_n [*4];
    endsequence
    sequence s_pause_req;
        (!cs_n && !lane_in[3] && !status_reg3[7] && !status_reg2[1]) [*4];
    endsequence
    chk_pause_sel: assert property (s_off |-> !paused)
        else $error("pause seen while deselected");
    chk_pause_float: assert property (paused |-> ##[0:3] lane_oe == 4'h0)
        else $error("lanes driven during pause");
    chk_pause_rise: assert property (s_pause_req |-> ##[0:2] paused)
        else $error("pause request not honoured");
    chk_qe_nopause: assert property (status_reg2[1] [*4] |-> !paused)
        else $error("pause active with quad enable set");
    chk_role_reset: assert property (status_reg3[7] [*4] |-> !paused)
        else $error("pause active in reset role");
    chk_busy_pass: assert property (busy [*3] |-> busy_seen)
        else $error("busy copy lost");
    chk_oe_lanes: assert property (lane_oe == 4'h0 || lane_oe == 4'hf)
        else $error("lane enables split");
    chk_desel_float: assert property (s_off |-> lane_oe == 4'h0)
        else $error("lanes driven while deselected");
    chk_prog_hold: assert property (prog_valid && !prog_ready |=>
        prog_valid && $stable(prog_data))
        else $error("program byte dropped under stall");
endmodule // sfp_pin_ctl_monitor
bind sfp_pin_ctl sfp_pin_ctl_monitor u_mon (.sys_clk, .rst, .cs_n, .lane_in,
    .lane_oe, .status_reg2, .status_reg3, .busy, .busy_seen, .prog_valid,
    .prog_ready, .prog_data, .paused);
`default_nettype wire

// *** sim/sfp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model (
    output logic link_clk,
    output logic cs_n,
    output logic [3:0] lane_in
);
    // clock stands still outside frames, pulled-up pin idles high
    initial begin
        link_clk = 1'b0;
        cs_n = 1'b1;
        lane_in = 4'hf;
    end
    task automatic clk4(input logic [3:0] v); // data set with clock low
        lane_in = v;
        #40 link_clk = 1'b1;
        #40 link_clk = 1'b0;
        lane_in = {1'b1, ~v[2:0]};
    endtask
    task automatic ser(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) clk4({3'b111, v[i]});
    endtask
    task automatic sel(input logic on); // select moves with clock low
        #40 cs_n = !on;
        lane_in = 4'hf;
    endtask
    task automatic pin3(input logic lvl); // pin moves with cs low, clock low
        lane_in[3] = lvl;
        #40;
    endtask
    task automatic wiggle(input int n);
        for (int i = 0; i < 2 * n; i++) begin
            lane_in[0] = ~lane_in[0];
            #40 link_clk = ~link_clk;
        end
    endtask
endmodule // sfp_host_model
`default_nettype wire

// *** sim/serial_flash_pause_lane3_pin_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_flash_pause_lane3_pin_tb_top;
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
        logic exp;
    } sfp_row_type;
    localparam sfp_row_type ROWS [3] = '{'{8'h32, 8'ha5, 1'b1},
        '{8'h32, 8'h0f, 1'b1}, '{8'h03, 8'hf0, 1'b0}};
    logic sys_clk, rst, link_clk, cs_n, busy, busy_seen, prog_valid;
    logic prog_ready, overrun, rd_ready, paused;
    logic rd_valid;
    logic [7:0] rd_data;
    logic [3:0] host_lanes, lane_out, lane_oe;
    logic [7:0] status_reg2, status_reg3, prog_data;
    wire logic [3:0] pin_lv = (lane_oe & lane_out) | (~lane_oe & host_lanes);
    int error_cnt = 0;
    int n_compared = 0;
    sfp_host_model host (.link_clk, .cs_n, .lane_in(host_lanes));
    sfp_pin_ctl dut (.sys_clk, .rst, .link_clk, .cs_n, .lane_in(pin_lv),
        .lane_out, .lane_oe, .status_reg2, .status_reg3, .busy, .busy_seen,
        .prog_valid, .prog_ready, .prog_data, .overrun, .rd_valid,
        .rd_data, .rd_ready, .paused);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic sys(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic pop(output logic ok, output logic [7:0] b);
        ok = 1'b0;
        b = 8'h00;
        @(posedge sys_clk) prog_ready <= 1'b1;
        for (int k = 0; k < 20 && !ok; k++) begin
            @(posedge sys_clk);
            if (prog_valid === 1'b1) begin
                ok = 1'b1;
                b = prog_data;
            end
        end
        prog_ready <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] cmd, input logic [31:0] nb, int n);
        host.sel(1'b1);
        host.ser({cmd, 24'h00_0000}, 32);
        for (int i = n - 1; i >= 0; i--) host.clk4(nb[i*4 +: 4]);
        host.sel(1'b0);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
    initial begin : main
        logic ok;
        logic [7:0] b;
        rst = 1'b1;
        busy = 1'b0;
        prog_ready = 1'b0;
        rd_valid = 1'b1;
        rd_data = 8'hc3;
        status_reg2 = 8'h02;
        status_reg3 = 8'h00;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        sys(3);
        @(posedge sys_clk) rd_data <= 8'h5a;
        foreach (ROWS[i]) begin
            frame(ROWS[i].cmd, {24'h00_0000, ROWS[i].data}, 2);
            pop(ok, b);
            check(ok, ROWS[i].exp);
            if (ROWS[i].exp) check(b, ROWS[i].data);
            $display("row %0d done", i);
        end
        host.sel(1'b1);
        host.ser({8'h6b, 24'h00_0000}, 32);
        host.ser(32'h0000_0000, 8);
        sys(4);
        check(lane_oe, 4'hf);
        check(lane_out, 4'hc);
        host.clk4(4'hf);
        sys(4);
        check(lane_out, 4'h3);
        host.clk4(4'hf);
        sys(4);
        check(lane_out, 4'h5);
        host.sel(1'b0);
        sys(4);
        check(lane_oe, 4'h0);
        $display("read test done");
        @(posedge sys_clk) status_reg2 <= 8'h00;
        host.sel(1'b1);
        host.ser(32'h0000_0003, 4);
        host.pin3(1'b0);
        @(posedge sys_clk) busy <= 1'b1;
        host.wiggle(3);
        sys(4);
        check(paused, 1'b1);
        check(lane_oe, 4'h0);
        check(busy_seen, 1'b1);
        host.pin3(1'b1);
        @(posedge sys_clk) status_reg2 <= 8'h02;
        sys(4);
        host.ser(32'h0200_0000, 28);
        host.clk4(4'h6);
        host.clk4(4'h9);
        host.sel(1'b0);
        pop(ok, b);
        check(b, 8'h69);
        busy <= 1'b0;
        $display("pause test done");
        @(posedge sys_clk) status_reg2 <= 8'h00;
        status_reg3 <= 8'h80;
        host.sel(1'b1);
        host.ser(32'h0000_0005, 3);
        host.pin3(1'b0);
        sys(4);
        check(paused, 1'b0);
        host.pin3(1'b1);
        @(posedge sys_clk) status_reg2 <= 8'h02;
        status_reg3 <= 8'h00;
        sys(4);
        frame(8'h32, 32'h0000_001e, 2);
        pop(ok, b);
        check(b, 8'h1e);
        $display("reset role test done");
        @(posedge sys_clk) prog_ready <= 1'b0;
        frame(8'h32, 32'h1122_3344, 8);
        sys(8);
        check(overrun, 1'b1);
        pop(ok, b);
        check(b, 8'h11);
        pop(ok, b);
        check(b, 8'h22);
        pop(ok, b);
        check(b, 8'h44);
        $display("buffer test done");
        @(posedge sys_clk) rst <= 1'b1;
        sys(2);
        check(overrun, 1'b0);
        check(prog_valid, 1'b0);
        @(posedge sys_clk) rst <= 1'b0;
        sys(3);
        $display("reset test done");
        print_verdict();
    end
endmodule // serial_flash_pause_lane3_pin_tb_top
`default_nettype wire
